/* common/feature_control_branch_record_consts.vh */
// Register map, field positions and reset values of the feature control and branch record bank
// Contract
// - While lock bit 20 is set, bit 20 and the transition enable ignore writes.
// - Every reset clears the transition lock, making guarded bits writable again.
// - Bit 37 set disables the next-line L1 prefetcher; reads 0 after reset.
// - Next-line prefetcher fetches following line after repeated same-line loads within a window.
// - Bit 38 set disables dynamic acceleration and clears the identification flag; clear enables.
// - Power-on value of bit 38 shows whether dynamic acceleration hardware exists.
// - Bit 39 set disables the instruction-pointer L1 prefetcher; reads 0 after reset.
// - Instruction-pointer prefetcher uses sequential load history to fetch the next expected line.
// - Stack top register holds a software read/write index in bits 3:0.
// - Read-only register captures the last branch source before an exception or interrupt.
// - Read-only register captures that same branch's target before the exception or interrupt.
// - Capability register reports record format 5:0, sample format 6, save flag 7.
`ifndef FEATURE_CONTROL_BRANCH_RECORD_CONSTS_VH
`define FEATURE_CONTROL_BRANCH_RECORD_CONSTS_VH

`define ADDR_W 13
`define IDX_BRANCH_STACK_TOP 11'h1c9
`define IDX_LER_SOURCE 11'h1dd
`define IDX_LER_TARGET 11'h1de
`define IDX_PERF_CAPABILITY 11'h345
`define IDX_MISC_FEATURE 11'h1a0
`define HIGH_WORD_BIT 12

`define BIT_PSTATE_ENABLE 16
`define BIT_PSTATE_LOCK 20
`define BIT_NEXT_LINE_DIS 37
`define BIT_ACCEL_DIS 38
`define BIT_IP_DIS 39
`define STACK_TOP_W 4

`define LINE_W 26
`define NEXT_LINE_WINDOW_NS 640
`define CLK_PERIOD_NS 10
`define NEXT_LINE_WINDOW_CYC (`NEXT_LINE_WINDOW_NS / `CLK_PERIOD_NS)
`define NEXT_LINE_HITS 3'h2
`define IP_SEQ_HITS 2'h2

`endif

/* hdl/feature_control_branch_record_regs.v */
// Feature control, branch record and capability registers with the two L1 prefetch engines
`timescale 1ns/1ps
`include "feature_control_branch_record_consts.vh"
module feature_control_branch_record_regs #(
  parameter ACCEL_PRESENT = 1'b1,
  parameter [5:0] BRANCH_RECORD_FORMAT = 6'h00,
  parameter SAMPLED_RECORD_FORMAT = 1'b0,
  parameter SAMPLED_ARCH_REG_SAVE = 1'b0
) (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Avalon-MM slave
  input wire [`ADDR_W-1:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg waitrequest,
  // Branch retirement and exception events
  input wire branch_valid,
  input wire [63:0] branch_source,
  input wire [63:0] branch_target,
  input wire exception_event,
  // Loads seen by the L1 data unit
  input wire load_valid,
  input wire [`LINE_W-1:0] load_line,
  input wire [15:0] load_ip,
  // Prefetch requests to the L1 data unit
  output reg next_line_pf_valid,
  output reg [`LINE_W-1:0] next_line_pf_line,
  output reg ip_pf_valid,
  output reg [`LINE_W-1:0] ip_pf_line,
  // Feature state
  output reg pstate_transition_enable,
  output reg pstate_transition_lock,
  output reg dynamic_acceleration_flag
);

  // Window length in cycles, cut to the timer width on purpose
  localparam integer WIN_CYC_FULL = `NEXT_LINE_WINDOW_CYC;
  localparam [6:0] WIN_CYC = WIN_CYC_FULL[6:0];
  // Bit positions of the one-hot register select
  localparam SEL_MISC = 0;
  localparam SEL_STACK_TOP = 1;
  localparam SEL_EXC_SOURCE = 2;
  localparam SEL_EXC_TARGET = 3;
  localparam SEL_CAPABILITY = 4;

  reg pstate_en_r;
  reg pstate_lock_r;
  reg next_line_dis_r;
  reg accel_dis_r;
  reg ip_dis_r;
  reg [`STACK_TOP_W-1:0] stack_top_r;
  reg [63:0] last_src_r;
  reg [63:0] last_dst_r;
  reg [63:0] ler_src_r;
  reg [63:0] ler_dst_r;
  reg [`LINE_W-1:0] nl_line_r;
  reg [2:0] nl_hits_r;
  reg [6:0] nl_timer_r;
  reg [15:0] ip_last_r;
  reg [`LINE_W-1:0] ip_line_r;
  reg [1:0] ip_seq_r;
  reg [63:0] rd_word;
  reg [31:0] rd_nxt;
  reg [63:0] wr_word;
  reg hit;

  wire [10:0] idx = address[11:2] == 10'h000 ? 11'h000 : {1'b0, address[11:2]};
  // Upper half of a 64-bit register is chosen by one byte-address bit
  wire high = address[`HIGH_WORD_BIT];
  wire wr_take = write && !waitrequest;

  // Byte-lane merge of one 32-bit half into a 64-bit register image
  function [63:0] merge;
    input [63:0] old;
    input [31:0] data;
    input [3:0] be;
    input upper;
    integer i;
    reg [31:0] half;
    begin
      half = upper ? old[63:32] : old[31:0];
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          half[i*8 +: 8] = data[i*8 +: 8];
        end
      end
      merge = upper ? {half, old[31:0]} : {old[63:32], half};
    end
  endfunction

  // Register image of the feature control register; other bits read zero
  function [63:0] misc_image;
    input en;
    input lock;
    input nl;
    input acc;
    input ipd;
    begin
      misc_image = 64'h0;
      misc_image[`BIT_PSTATE_ENABLE] = en;
      misc_image[`BIT_PSTATE_LOCK] = lock;
      misc_image[`BIT_NEXT_LINE_DIS] = nl;
      misc_image[`BIT_ACCEL_DIS] = acc;
      misc_image[`BIT_IP_DIS] = ipd;
    end
  endfunction

  // One-hot register select from the word index; all zero when unmapped
  function [4:0] reg_sel;
    input [10:0] index;
    begin
      reg_sel = 5'h00;
      if (index == `IDX_MISC_FEATURE) begin
        reg_sel[SEL_MISC] = 1'b1;
      end else if (index == `IDX_BRANCH_STACK_TOP) begin
        reg_sel[SEL_STACK_TOP] = 1'b1;
      end else if (index == `IDX_LER_SOURCE) begin
        reg_sel[SEL_EXC_SOURCE] = 1'b1;
      end else if (index == `IDX_LER_TARGET) begin
        reg_sel[SEL_EXC_TARGET] = 1'b1;
      end else if (index == `IDX_PERF_CAPABILITY) begin
        reg_sel[SEL_CAPABILITY] = 1'b1;
      end
    end
  endfunction

  // Address of the cache line that follows a given line
  function [`LINE_W-1:0] line_after;
    input [`LINE_W-1:0] cur;
    begin
      line_after = cur + {{(`LINE_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // Register select and prefetch match terms
  wire [4:0] sel = reg_sel(idx);
  wire nl_same = load_line == nl_line_r && nl_timer_r != 7'h00;
  wire ip_seq_hit = load_ip == ip_last_r && load_line == line_after(ip_line_r);

  // Read decode
  always @* begin
    hit = 1'b1;
    rd_word = 64'h0;
    if (sel[SEL_MISC]) begin
      rd_word = misc_image(pstate_en_r, pstate_lock_r, next_line_dis_r, accel_dis_r, ip_dis_r);
    end else if (sel[SEL_STACK_TOP]) begin
      rd_word = {60'h0, stack_top_r};
    end else if (sel[SEL_EXC_SOURCE]) begin
      rd_word = ler_src_r;
    end else if (sel[SEL_EXC_TARGET]) begin
      rd_word = ler_dst_r;
    end else if (sel[SEL_CAPABILITY]) begin
      // Fixed capability report, reserved bits zero
      rd_word = {56'h0, SAMPLED_ARCH_REG_SAVE != 0, SAMPLED_RECORD_FORMAT != 0,
                 BRANCH_RECORD_FORMAT};
    end else begin
      hit = 1'b0;
    end
    rd_nxt = high ? rd_word[63:32] : rd_word[31:0];
    wr_word = merge(rd_word, writedata, byteenable, high);
  end

  // Bus handshake: one wait cycle, then answer for one cycle
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0;
    end else begin
      if ((read || write) && waitrequest) begin
        waitrequest <= 1'b0;
        // Unmapped indices answer with zero
        readdata <= hit ? rd_nxt : 32'h0;
      end else begin
        waitrequest <= 1'b1;
      end
    end
  end

  // Writable control fields
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pstate_en_r <= 1'b0;
      pstate_lock_r <= 1'b0;
      next_line_dis_r <= 1'b0;
      ip_dis_r <= 1'b0;
      accel_dis_r <= ACCEL_PRESENT != 0;
      stack_top_r <= 4'h0;
    end else if (wr_take && hit) begin
      if (sel[SEL_MISC]) begin
        // Lock and enable stay frozen until the next reset
        if (!pstate_lock_r) begin
          pstate_en_r <= wr_word[`BIT_PSTATE_ENABLE];
          pstate_lock_r <= wr_word[`BIT_PSTATE_LOCK];
        end
        next_line_dis_r <= wr_word[`BIT_NEXT_LINE_DIS];
        accel_dis_r <= wr_word[`BIT_ACCEL_DIS];
        ip_dis_r <= wr_word[`BIT_IP_DIS];
      end else if (sel[SEL_STACK_TOP]) begin
        stack_top_r <= wr_word[`STACK_TOP_W-1:0];
      end
    end
  end

  // Last branch tracking and capture at exception or interrupt
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      last_src_r <= 64'h0;
      last_dst_r <= 64'h0;
      ler_src_r <= 64'h0;
      ler_dst_r <= 64'h0;
    end else begin
      if (branch_valid) begin
        last_src_r <= branch_source;
        last_dst_r <= branch_target;
      end
      // A branch in the same cycle as the event is the one recorded
      if (exception_event) begin
        ler_src_r <= branch_valid ? branch_source : last_src_r;
        ler_dst_r <= branch_valid ? branch_target : last_dst_r;
      end
    end
  end

  // Next-line prefetcher: repeated loads to one line within the window
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      nl_line_r <= {`LINE_W{1'b0}};
      nl_hits_r <= 3'h0;
      nl_timer_r <= 7'h00;
      next_line_pf_valid <= 1'b0;
      next_line_pf_line <= {`LINE_W{1'b0}};
    end else begin
      next_line_pf_valid <= 1'b0;
      if (nl_timer_r != 7'h00) begin
        nl_timer_r <= nl_timer_r - 7'h01;
      end
      if (load_valid) begin
        if (nl_same) begin
          if (nl_hits_r + 3'h1 >= `NEXT_LINE_HITS && !next_line_dis_r) begin
            next_line_pf_valid <= 1'b1;
            next_line_pf_line <= line_after(load_line);
            nl_hits_r <= 3'h0;
            nl_timer_r <= 7'h00;
          end else begin
            nl_hits_r <= nl_hits_r + 3'h1;
          end
        end else begin
          nl_line_r <= load_line;
          nl_hits_r <= 3'h1;
          nl_timer_r <= WIN_CYC;
        end
      end
    end
  end

  // Instruction-pointer prefetcher: sequential lines from one load site
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ip_last_r <= 16'h0;
      ip_line_r <= {`LINE_W{1'b0}};
      ip_seq_r <= 2'h0;
      ip_pf_valid <= 1'b0;
      ip_pf_line <= {`LINE_W{1'b0}};
    end else begin
      ip_pf_valid <= 1'b0;
      if (load_valid) begin
        ip_last_r <= load_ip;
        ip_line_r <= load_line;
        if (ip_seq_hit) begin
          if (ip_seq_r + 2'h1 >= `IP_SEQ_HITS) begin
            ip_pf_valid <= !ip_dis_r;
            ip_pf_line <= line_after(load_line);
          end else begin
            ip_seq_r <= ip_seq_r + 2'h1;
          end
        end else begin
          ip_seq_r <= 2'h0;
        end
      end
    end
  end

  // Registered feature state outputs
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pstate_transition_enable <= 1'b0;
      pstate_transition_lock <= 1'b0;
      dynamic_acceleration_flag <= 1'b0;
    end else begin
      pstate_transition_enable <= pstate_en_r;
      pstate_transition_lock <= pstate_lock_r;
      // Flag stays clear on parts without the feature
      dynamic_acceleration_flag <= ACCEL_PRESENT && !accel_dis_r;
    end
  end

endmodule

/* tb/fcbr_monitor.sv */
// Concurrent checks on the ports of the feature control and branch record bank
`timescale 1ns/1ps
module fcbr_monitor (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Register bus
  input wire read,
  input wire write,
  input wire [31:0] readdata,
  input wire waitrequest,
  // Loads and prefetch requests
  input wire load_valid,
  input wire [25:0] load_line,
  input wire next_line_pf_valid,
  input wire [25:0] next_line_pf_line,
  input wire ip_pf_valid,
  input wire [25:0] ip_pf_line,
  // Feature state
  input wire pstate_transition_enable,
  input wire pstate_transition_lock,
  input wire dynamic_acceleration_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence bus_start;
    (read || write) && waitrequest;
  endsequence
  sequence ack_pulse;
    !waitrequest ##1 waitrequest;
  endsequence
  chk_answer_one: assert property (bus_start |=> ack_pulse)
    else $error("bus answer timing wrong");
  chk_rdata_hold: assert property ($changed(readdata) |-> !waitrequest)
    else $error("read data moved outside answer");
  chk_lock_sticky: assert property (pstate_transition_lock |=> pstate_transition_lock)
    else $error("lock dropped without reset");
  chk_enable_frozen: assert property (pstate_transition_lock |=> $stable(pstate_transition_enable))
    else $error("enable moved while locked");
  chk_lock_by_write: assert property ($rose(pstate_transition_lock) |-> $past(write && !waitrequest, 2))
    else $error("lock set without a write");
  chk_flag_cause: assert property ($changed(dynamic_acceleration_flag) |-> $past(write, 2) && !$past(waitrequest, 2))
    else $error("flag moved without a write");
  chk_nl_line: assert property (next_line_pf_valid |-> $past(load_valid) && next_line_pf_line == $past(load_line) + 26'h1)
    else $error("next line request wrong");
  chk_ip_line: assert property (ip_pf_valid |-> $past(load_valid) && ip_pf_line == $past(load_line) + 26'h1)
    else $error("ip request wrong");
endmodule
bind feature_control_branch_record_regs fcbr_monitor mon (
  .mclk(mclk), .arst_n(arst_n), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .load_valid(load_valid), .load_line(load_line),
  .next_line_pf_valid(next_line_pf_valid), .next_line_pf_line(next_line_pf_line),
  .ip_pf_valid(ip_pf_valid), .ip_pf_line(ip_pf_line),
  .pstate_transition_enable(pstate_transition_enable),
  .pstate_transition_lock(pstate_transition_lock),
  .dynamic_acceleration_flag(dynamic_acceleration_flag)
);

/* tb/tb_top.sv */
// Self-checking bench for the feature control and branch record bank
`timescale 1ns/1ps
module tb_top;
  reg mclk = 0, arst_n = 0, read = 0, write = 0;
  reg branch_valid = 0, exception_event = 0, load_valid = 0;
  reg [12:0] address = 0;
  reg [31:0] writedata = 0;
  reg [63:0] branch_source = 0, branch_target = 0;
  reg [25:0] load_line = 0, nl_last, ip_last;
  reg [15:0] load_ip = 16'h0042;
  reg [31:0] rd;
  wire [31:0] readdata;
  wire waitrequest, next_line_pf_valid, ip_pf_valid, dynamic_acceleration_flag;
  wire pstate_transition_enable, pstate_transition_lock;
  wire [25:0] next_line_pf_line, ip_pf_line;
  integer n_fail = 0, n_compared = 0, nl_cnt = 0, ip_cnt = 0;
  always #5 mclk = ~mclk;
  feature_control_branch_record_regs dut (
    .mclk(mclk), .arst_n(arst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
    .waitrequest(waitrequest), .branch_valid(branch_valid),
    .branch_source(branch_source), .branch_target(branch_target),
    .exception_event(exception_event), .load_valid(load_valid), .load_line(load_line),
    .load_ip(load_ip), .next_line_pf_valid(next_line_pf_valid),
    .next_line_pf_line(next_line_pf_line), .ip_pf_valid(ip_pf_valid),
    .ip_pf_line(ip_pf_line), .pstate_transition_enable(pstate_transition_enable),
    .pstate_transition_lock(pstate_transition_lock),
    .dynamic_acceleration_flag(dynamic_acceleration_flag)
  );
  always @(posedge mclk) begin
    if (next_line_pf_valid) begin
      nl_cnt <= nl_cnt + 1;
      nl_last <= next_line_pf_line;
    end
    if (ip_pf_valid) begin
      ip_cnt <= ip_cnt + 1;
      ip_last <= ip_pf_line;
    end
  end
  task summarize;
    begin
      if (n_fail == 0 && n_compared > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [8*12:1] name, input [31:0] exp, input [31:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  task bus(input w, input [12:0] a, input [31:0] d);
    integer i;
    begin
      read <= !w;
      write <= w;
      address <= a;
      writedata <= d;
      i = 0;
      do begin
        @(posedge mclk);
        i = i + 1;
      end while (waitrequest !== 1'b0 && i < 20);
      if (waitrequest !== 1'b0) begin
        n_fail = n_fail + 1;
        summarize;
      end else begin
        rd = readdata;
        read <= 0;
        write <= 0;
        @(posedge mclk);
      end
    end
  endtask
  task rdchk(input [12:0] a, input [31:0] exp, input [8*12:1] name);
    begin
      bus(0, a, 0);
      chk(name, exp, rd);
    end
  endtask
  task loads(input [25:0] l0, input [25:0] step, input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        load_line <= l0 + step * i[25:0];
        load_valid <= 1;
        tick(1);
      end
      load_valid <= 0;
      tick(3);
    end
  endtask
  task t_reset_vals;
    begin
      rdchk(13'h0680, 32'h0, "feat_lo");
      rdchk(13'h1680, 32'h40, "feat_hi");
      chk("accel_flag", 0, {31'h0, dynamic_acceleration_flag});
      rdchk(13'h0d14, 32'h0, "cap_lo");
      rdchk(13'h1d14, 32'h0, "cap_hi");
      rdchk(13'h0004, 32'h0, "unmapped");
    end
  endtask
  task t_accel;
    begin
      bus(1, 13'h1680, 32'hffffffff);
      rdchk(13'h1680, 32'he0, "feat_hi_rsv");
      bus(1, 13'h1680, 32'h0);
      tick(2);
      chk("flag_on", 1, {31'h0, dynamic_acceleration_flag});
      bus(1, 13'h1680, 32'h40);
      tick(2);
      chk("flag_off", 0, {31'h0, dynamic_acceleration_flag});
    end
  endtask
  task t_lock;
    begin
      bus(1, 13'h0680, 32'hffefffff);
      rdchk(13'h0680, 32'h00010000, "feat_lo_rsv");
      bus(1, 13'h0680, 32'h00100000);
      bus(1, 13'h0680, 32'h00010000);
      rdchk(13'h0680, 32'h00100000, "locked");
      chk("lock_out", 1, {31'h0, pstate_transition_lock});
      chk("en_locked", 0, {31'h0, pstate_transition_enable});
      arst_n <= 0;
      tick(2);
      arst_n <= 1;
      tick(1);
      rdchk(13'h0680, 32'h0, "lock_reset");
      bus(1, 13'h0680, 32'h00010000);
      rdchk(13'h0680, 32'h00010000, "unlocked");
      chk("en_out", 1, {31'h0, pstate_transition_enable});
      bus(1, 13'h0724, 32'hfffffffb);
      rdchk(13'h0724, 32'hb, "stack_top");
    end
  endtask
  task t_ler;
    begin
      branch_source <= 64'h000000ab_12345678;
      branch_target <= 64'h000000cd_9abcdef0;
      branch_valid <= 1;
      tick(1);
      branch_valid <= 0;
      exception_event <= 1;
      tick(1);
      exception_event <= 0;
      branch_source <= 64'h1;
      branch_target <= 64'h2;
      branch_valid <= 1;
      tick(1);
      branch_valid <= 0;
      bus(1, 13'h0774, 32'h0);
      rdchk(13'h0774, 32'h12345678, "ler_src_lo");
      rdchk(13'h1774, 32'h000000ab, "ler_src_hi");
      rdchk(13'h0778, 32'h9abcdef0, "ler_tgt_lo");
    end
  endtask
  task t_pref;
    begin
      loads(26'h200, 26'h0, 2);
      chk("nl_count", 1, nl_cnt);
      chk("nl_line", 32'h201, {6'h0, nl_last});
      loads(26'h300, 26'h1, 3);
      chk("ip_count", 1, ip_cnt);
      chk("ip_line", 32'h303, {6'h0, ip_last});
      bus(1, 13'h1680, 32'ha0);
      loads(26'h400, 26'h0, 2);
      loads(26'h500, 26'h1, 3);
      chk("nl_off", 1, nl_cnt);
      chk("ip_off", 1, ip_cnt);
    end
  endtask
  initial begin
    tick(6);
    arst_n <= 1;
    tick(1);
    t_reset_vals;
    t_accel;
    t_lock;
    t_ler;
    t_pref;
    summarize;
  end
endmodule
